//--- fsc_float_regs.sv
`timescale 1ns/100ps
`default_nettype none
module fsc_float_regs
  import fsc_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   wrEn,
  input  wire logic [FSC_FREG_AW-1:0] wrAddr,
  input  wire logic [FSC_FREG_W-1:0]  wrData,
  input  wire logic [FSC_FREG_AW-1:0] rdAddrA,
  input  wire logic [FSC_FREG_AW-1:0] rdAddrB,
  output logic      [FSC_FREG_W-1:0]  rdDataA_r,
  output logic      [FSC_FREG_W-1:0]  rdDataB_r
);
  // contents survive reset, so the array has no reset branch
  logic [FSC_FREG_W-1:0] floatRegister [FSC_FREG_N];
  logic [FSC_FREG_W-1:0] rdDataA_nxt;
  logic [FSC_FREG_W-1:0] rdDataB_nxt;

  always_comb
  begin
    rdDataA_nxt = floatRegister[rdAddrA];
    rdDataB_nxt = floatRegister[rdAddrB];
  end

  always_ff @(posedge ref_clk)
  begin
    if (wrEn)
    begin
      floatRegister[wrAddr] <= wrData;
    end
  end

  // read ports see the old word on a same-cycle write
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdDataA_r <= FSC_RD_RESET;
      rdDataB_r <= FSC_RD_RESET;
    end
    else
    begin
      rdDataA_r <= rdDataA_nxt;
      rdDataB_r <= rdDataB_nxt;
    end
  end

  property p_write_read;
    @(posedge ref_clk) disable iff (sys_rst)
    wrEn ##1 (!wrEn && rdAddrA == $past(wrAddr)) |=> rdDataA_r == $past(wrData, 2);
  endproperty
  a_write_read: assert property (p_write_read) else $error("register file lost a write");
endmodule
`default_nettype wire

//--- fsc_fpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module fsc_fpu_model
  import fsc_pkg::*;
(
  input  wire logic   ref_clk,
  output logic        statusValid,
  output logic [0:31] excFlags,
  output logic [0:7]  resultFlags,
  output logic        opValid,
  output fsc_op_t     opCode,
  output logic [2:0]  opField,
  output logic [0:7]  opFieldMask,
  output logic [0:31] opData,
  output logic [3:0]  opImm,
  output logic [4:0]  opBit
);
  initial
  begin
    statusValid = 1'b0;
    opValid = 1'b0;
    {excFlags, resultFlags, opField, opFieldMask, opData, opImm, opBit} = '0;
    opCode = FSC_OP_FIELD_TO_COND;
  end
  // entered just after an edge; taken at the next edge, pulses left up for back-to-back use
  task automatic issue(input logic sv, input logic [0:31] ex, input logic [0:7] rs,
    input logic ov, input logic [2:0] c, input logic [2:0] f, input logic [0:7] m,
    input logic [0:31] d, input logic [3:0] im, input logic [4:0] b);
    statusValid = sv;
    excFlags = ex;
    resultFlags = rs;
    opValid = ov;
    opCode = fsc_op_t'(c);
    {opField, opFieldMask, opData, opImm, opBit} = {f, m, d, im, b};
    @(posedge ref_clk);
    #1;
  endtask
  // qualifiers dropped; flags, data, immediate and bit number inverted so a stale value never looks valid
  task automatic idle();
    statusValid = 1'b0;
    opValid = 1'b0;
    {excFlags, resultFlags, opData, opImm, opBit} = ~{excFlags, resultFlags, opData, opImm, opBit};
    @(posedge ref_clk);
    #1;
  endtask
endmodule
`default_nettype wire

//--- fsc_pkg.sv
`default_nettype none
package fsc_pkg;
  // status word is numbered msb-first: bit 0 is the exception summary
  localparam int FSC_WORD_W      = 32;
  localparam int FSC_FREG_W      = 64;
  localparam int FSC_FREG_N      = 32;
  localparam int FSC_FREG_AW     = 5;
  localparam int FSC_STATUS_LO   = 0;
  localparam int FSC_STATUS_HI   = 23;
  localparam int FSC_CTRL_LO     = 24;
  localparam int FSC_CTRL_HI     = 31;
  localparam int FSC_FX_BIT      = 0;
  localparam int FSC_FEX_BIT     = 1;
  localparam int FSC_VX_BIT      = 2;
  localparam int FSC_OX_BIT      = 3;
  localparam int FSC_UX_BIT      = 4;
  localparam int FSC_ZX_BIT      = 5;
  localparam int FSC_FR_BIT      = 13;
  localparam int FSC_RES_LO      = 13;
  localparam int FSC_RES_W       = 8;
  // enable k sits at FSC_EN_LO+k and guards summary/exception bit FSC_VX_BIT+k
  localparam int FSC_EN_LO       = 24;
  localparam int FSC_EN_N        = 5;
  localparam int FSC_FIELD_N     = 8;
  // masks written msb-first to match the bit numbering
  localparam logic [0:31] FSC_STICKY_MASK  = 32'h9FF80700;
  localparam logic [0:31] FSC_EXC_MASK     = 32'h1FF80700;
  localparam logic [0:31] FSC_INVALID_MASK = 32'h01F80700;
  localparam logic [63:0] FSC_RD_RESET     = 64'h0000000000000000;
  localparam logic [3:0]  FSC_COND_RESET   = 4'h0;

  typedef enum logic [2:0] {
    FSC_OP_FIELD_TO_COND = 3'b000,
    FSC_OP_TO_FIELDS     = 3'b001,
    FSC_OP_IMM_TO_FIELD  = 3'b010,
    FSC_OP_CLEAR_BIT     = 3'b011,
    FSC_OP_SET_BIT       = 3'b100
  } fsc_op_t;
endpackage
`default_nettype wire

//--- fsc_status_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module fsc_status_ctrl
  import fsc_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   wbValid,
  input  wire logic [FSC_FREG_AW-1:0] wbAddr,
  input  wire logic [FSC_FREG_W-1:0]  wbData,
  input  wire logic [FSC_FREG_AW-1:0] rdAddrA,
  input  wire logic [FSC_FREG_AW-1:0] rdAddrB,
  output logic      [FSC_FREG_W-1:0]  rdDataA_r,
  output logic      [FSC_FREG_W-1:0]  rdDataB_r,
  input  wire logic                   statusValid,
  input  wire logic [0:31]            excFlags,
  input  wire logic [0:7]             resultFlags,
  input  wire logic                   opValid,
  input  wire fsc_op_t                opCode,
  input  wire logic [2:0]             opField,
  input  wire logic [0:7]             opFieldMask,
  input  wire logic [0:31]            opData,
  input  wire logic [3:0]             opImm,
  input  wire logic [4:0]             opBit,
  output logic      [0:31]            floatStatusControl_r,
  output logic      [3:0]             condField_r,
  output logic                        condValid_r
);
  logic [0:31] floatStatusControl_nxt;
  logic [3:0]  condField_nxt;
  logic        condValid_nxt;
  logic [0:31] work;
  logic [0:31] rise;
  logic [4:0]  fieldIdx;
  logic        enabledAny;
  logic        primed_r;

  fsc_float_regs u_regs (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .wrEn      (wbValid),
    .wrAddr    (wbAddr),
    .wrData    (wbData),
    .rdAddrA   (rdAddrA),
    .rdAddrB   (rdAddrB),
    .rdDataA_r (rdDataA_r),
    .rdDataB_r (rdDataB_r)
  );

  always_comb
  begin
    work          = floatStatusControl_r;
    rise          = '0;
    fieldIdx      = {opField, 2'b00};
    enabledAny    = 1'b0;
    condField_nxt = condField_r;
    condValid_nxt = 1'b0;
    if (opValid)
    begin
      unique case (opCode)
        FSC_OP_FIELD_TO_COND:
        begin
          // copy first, then drop the copied exception bits
          condField_nxt        = floatStatusControl_r[fieldIdx +: 4];
          condValid_nxt        = 1'b1;
          work[fieldIdx +: 4]  = work[fieldIdx +: 4] & ~FSC_STICKY_MASK[fieldIdx +: 4];
        end
        FSC_OP_TO_FIELDS:
        begin
          for (int k = 0; k < FSC_FIELD_N; k++)
          begin
            if (opFieldMask[k])
            begin
              work[4*k +: 4] = opData[4*k +: 4];
            end
          end
        end
        FSC_OP_IMM_TO_FIELD:
        begin
          work[fieldIdx +: 4] = opImm;
        end
        FSC_OP_CLEAR_BIT:
        begin
          work[opBit] = 1'b0;
        end
        FSC_OP_SET_BIT:
        begin
          work[opBit] = 1'b1;
        end
        default:
        begin
          work = floatStatusControl_r;
        end
      endcase
    end
    // writeback sets after the instruction so a same-cycle event is kept
    if (statusValid)
    begin
      rise = excFlags & FSC_EXC_MASK & ~work;
      work = work | (excFlags & FSC_EXC_MASK);
      if (|rise)
      begin
        work[FSC_FX_BIT] = 1'b1;
      end
      work[FSC_RES_LO +: FSC_RES_W] = resultFlags;
    end
    // derived bits overwrite anything an instruction put there
    work[FSC_VX_BIT] = |(work & FSC_INVALID_MASK);
    for (int k = 0; k < FSC_EN_N; k++)
    begin
      enabledAny = enabledAny | (work[FSC_VX_BIT + k] & work[FSC_EN_LO + k]);
    end
    work[FSC_FEX_BIT]      = enabledAny;
    floatStatusControl_nxt = work;
  end

  // no reset: the status word keeps its contents across reset
  always_ff @(posedge ref_clk)
  begin
    floatStatusControl_r <= floatStatusControl_nxt;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      condField_r <= FSC_COND_RESET;
      condValid_r <= 1'b0;
    end
    else
    begin
      condField_r <= condField_nxt;
      condValid_r <= condValid_nxt;
    end
  end

  // helper for checks: word is fully known after one all-fields move
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      primed_r <= 1'b0;
    end
    else if (opValid && opCode == FSC_OP_TO_FIELDS && opFieldMask == 8'hFF)
    begin
      primed_r <= 1'b1;
    end
  end

  property p_sticky_hold;
    @(posedge ref_clk) disable iff (sys_rst || !primed_r)
    !opValid |=> ((floatStatusControl_r & $past(floatStatusControl_r) & FSC_STICKY_MASK)
                 == ($past(floatStatusControl_r) & FSC_STICKY_MASK));
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("sticky bit dropped");

  property p_enabled_summary;
    @(posedge ref_clk) disable iff (sys_rst || !primed_r)
    ##1 floatStatusControl_r[FSC_FEX_BIT] ==
      |(floatStatusControl_r[FSC_VX_BIT +: FSC_EN_N] & floatStatusControl_r[FSC_EN_LO +: FSC_EN_N]);
  endproperty
  a_enabled_summary: assert property (p_enabled_summary) else $error("enabled summary wrong");

  property p_invalid_summary;
    @(posedge ref_clk) disable iff (sys_rst || !primed_r)
    ##1 floatStatusControl_r[FSC_VX_BIT] == |(floatStatusControl_r & FSC_INVALID_MASK);
  endproperty
  a_invalid_summary: assert property (p_invalid_summary) else $error("invalid summary wrong");

  property p_rise_sets_summary;
    @(posedge ref_clk) disable iff (sys_rst || !primed_r)
    (statusValid && !opValid && |(excFlags & FSC_EXC_MASK & ~floatStatusControl_r))
      |=> floatStatusControl_r[FSC_FX_BIT];
  endproperty
  a_rise_sets_summary: assert property (p_rise_sets_summary) else $error("summary not set");

  property p_copy_clears_summary;
    @(posedge ref_clk) disable iff (sys_rst)
    (opValid && opCode == FSC_OP_FIELD_TO_COND && opField == 3'h0 && !statusValid)
      |=> !floatStatusControl_r[FSC_FX_BIT] && condValid_r ##1 !condValid_r || $past(opValid);
  endproperty
  a_copy_clears_summary: assert property (p_copy_clears_summary) else $error("copy kept summary");

  property p_set_bit_summary;
    @(posedge ref_clk) disable iff (sys_rst)
    (opValid && opCode == FSC_OP_SET_BIT && opBit == 5'h00) |=> floatStatusControl_r[FSC_FX_BIT];
  endproperty
  a_set_bit_summary: assert property (p_set_bit_summary) else $error("set bit ignored");

  property p_overflow_recorded;
    @(posedge ref_clk) disable iff (sys_rst)
    (statusValid && excFlags[FSC_OX_BIT] && excFlags[FSC_ZX_BIT])
      |=> floatStatusControl_r[FSC_OX_BIT] && floatStatusControl_r[FSC_ZX_BIT];
  endproperty
  a_overflow_recorded: assert property (p_overflow_recorded) else $error("flag not recorded");

  property p_round_flag;
    @(posedge ref_clk) disable iff (sys_rst)
    statusValid |=> floatStatusControl_r[FSC_FR_BIT] == $past(resultFlags[0]);
  endproperty
  a_round_flag: assert property (p_round_flag) else $error("fraction rounded flag wrong");

  c_copy_field: cover property (@(posedge ref_clk) disable iff (sys_rst) condValid_r);
  c_exception_rise: cover property (@(posedge ref_clk) disable iff (sys_rst)
    statusValid && excFlags[FSC_UX_BIT] ##1 floatStatusControl_r[FSC_FX_BIT]);
  c_clear_bit: cover property (@(posedge ref_clk) disable iff (sys_rst)
    opValid && opCode == FSC_OP_CLEAR_BIT);
endmodule
`default_nettype wire

//--- tb_fsc_status_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module tb_fsc_status_ctrl
  import fsc_pkg::*;
;
  logic        ref_clk;
  logic        sys_rst;
  logic        wbValid;
  logic [4:0]  wbAddr;
  logic [63:0] wbData;
  logic [4:0]  rdAddrA;
  logic [4:0]  rdAddrB;
  logic [63:0] rdDataA_r;
  logic [63:0] rdDataB_r;
  logic        statusValid;
  logic [0:31] excFlags;
  logic [0:7]  resultFlags;
  logic        opValid;
  fsc_op_t     opCode;
  logic [2:0]  opField;
  logic [0:7]  opFieldMask;
  logic [0:31] opData;
  logic [3:0]  opImm;
  logic [4:0]  opBit;
  logic [0:31] floatStatusControl_r;
  logic [3:0]  condField_r;
  logic        condValid_r;
  logic [0:31] w;
  logic [63:0] rf [32];
  int          n_errors;
  int          checked;

  fsc_status_ctrl dut_u (.ref_clk, .sys_rst, .wbValid, .wbAddr, .wbData, .rdAddrA, .rdAddrB,
    .rdDataA_r, .rdDataB_r, .statusValid, .excFlags, .resultFlags, .opValid, .opCode, .opField,
    .opFieldMask, .opData, .opImm, .opBit, .floatStatusControl_r, .condField_r, .condValid_r);
  fsc_fpu_model m_u (.ref_clk, .statusValid, .excFlags, .resultFlags, .opValid, .opCode,
    .opField, .opFieldMask, .opData, .opImm, .opBit);

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // instruction first, then writeback sets, then the two summaries recomputed
  function automatic logic [0:31] nxt(input logic [0:31] o, input logic sv, input logic [0:31] ex,
    input logic [0:7] rs, input logic ov, input logic [2:0] c, input logic [2:0] f,
    input logic [0:7] m, input logic [0:31] d, input logic [3:0] im, input logic [4:0] b);
    if (ov)
      for (int i = 0; i < 32; i++)
      begin
        if (c == 3'h0 && i / 4 == f && FSC_STICKY_MASK[i]) o[i] = 1'b0;
        if (c == 3'h1 && m[i / 4]) o[i] = d[i];
        if (c == 3'h2 && i / 4 == f) o[i] = im[3 - i % 4];
        if (c == 3'h3 && i == b) o[i] = 1'b0;
        if (c == 3'h4 && i == b) o[i] = 1'b1;
      end
    if (sv)
    begin
      if (|(ex & FSC_EXC_MASK & ~o)) o[0] = 1'b1;
      o = o | (ex & FSC_EXC_MASK);
      o[13:20] = rs;
    end
    o[2] = |(o & FSC_INVALID_MASK);
    o[1] = |(o[2:6] & o[24:28]);
    return o;
  endfunction

  task automatic chk_status(input logic [0:31] e);
    checked++;
    if (floatStatusControl_r !== e)
    begin
      n_errors++;
      $display("wrong value status word expected %h seen %h", e, floatStatusControl_r);
    end
  endtask

  task automatic chk_data(input string nm, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic step(input logic sv, input logic [0:31] ex, input logic ov, input logic [2:0] c,
    input logic [2:0] f, input logic [0:7] m, input logic [0:31] d, input logic [4:0] b);
    logic [0:31] e;
    logic [0:7]  rs;
    logic [3:0]  im;
    rs = 8'($urandom);
    im = 4'($urandom);
    e = nxt(w, sv, ex, rs, ov, c, f, m, d, im, b);
    m_u.issue(sv, ex, rs, ov, c, f, m, d, im, b);
    chk_status(e);
    chk_data("copy pulse", 64'(ov && c == 3'h0), 64'(condValid_r));
    if (ov && c == 3'h0) chk_data("copy field", 64'(w[4 * f +: 4]), 64'(condField_r));
    w = e;
  endtask

  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #1000000;
    n_errors++;
    final_report();
  end

  initial
  begin
    logic sv;
    {n_errors, checked, w} = '0;
    {sys_rst, wbValid, wbAddr, wbData, rdAddrA, rdAddrB} = {1'b1, 80'h0};
    void'($urandom(32'h54C7E689));
    repeat (20) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    step(1'b0, 32'h0, 1'b1, 3'h1, 3'h0, 8'hFF, $urandom, 5'h00);
    for (int j = 0; j < 6; j++)
    begin
      step(1'b0, 32'h0, 1'b1, 3'h1, 3'h0, 8'hFF, 32'h000000F8, 5'h00);
      step(1'b0, 32'h0, 1'b1, 3'h4, 3'h0, 8'h00, 32'h0, 5'(j));
      step(1'b0, 32'h0, 1'b1, 3'h3, 3'h0, 8'h00, 32'h0, 5'(j));
      step(1'b1, 32'h10000000 >> j, 1'b0, 3'h0, 3'h0, 8'h00, 32'h0, 5'h00);
      step(1'b1, 32'h10000000 >> j, 1'b0, 3'h0, 3'h0, 8'h00, 32'h0, 5'h00);
      step(1'b0, 32'h0, 1'b1, 3'h0, 3'(j / 4), 8'h00, 32'h0, 5'h00);
      step(1'b0, 32'h0, 1'b1, 3'h0, 3'h0, 8'h00, 32'h0, 5'h00);
    end
    for (int k = 0; k < 400; k++)
    begin
      sv = 1'($urandom);
      // instruction and writeback in one cycle too, so set-over-clear is exercised
      step(sv, $urandom & $urandom, !sv | 1'($urandom), 3'($urandom), 3'($urandom), 8'($urandom),
        $urandom, 5'($urandom));
      if ($urandom_range(3) == 0) m_u.idle();
    end
    m_u.idle();
    for (int i = 0; i < 32; i++)
    begin
      rf[i] = {$urandom, $urandom};
      {wbValid, wbAddr, wbData} = {1'b1, 5'(i), rf[i]};
      @(posedge ref_clk);
      #1;
    end
    wbValid = 1'b0;
    for (int i = 0; i < 32; i++)
    begin
      {rdAddrA, rdAddrB} = {5'(31 - i), 5'(i)};
      @(posedge ref_clk);
      #1;
      chk_data("read port a", rf[31 - i], rdDataA_r);
      chk_data("read port b", rf[i], rdDataB_r);
    end
    sys_rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    rdAddrA = 5'h07;
    @(posedge ref_clk);
    #1;
    chk_status(w);
    chk_data("read after reset", rf[7], rdDataA_r);
    final_report();
  end
endmodule
`default_nettype wire
